/* design/sfirq_core.sv */
// Status flags, interrupt control register and vectored interrupt entry
//
// How it works
// - Every data operation stores result and updates flags
// - Status writes never touch watchdog or sleep flags
// - Watchdog flag: set by time-out, cleared by kick/sleep
// - Sleep flag: set by sleep, cleared by kick
// - Carry: add carry, subtract no-borrow, rotate-through-carry
// - Nibble carry: low nibble carry or no borrow
// - Zero flag follows zero result of add, subtract and logic; rotates keep it
// - Overflow: carry into msb differs from out
// - Interrupt entry pushes program counter only
// - Servicing clears global enable
// - Requests set pending flags even while blocked
// - Full stack blocks acknowledgement
// - Service pushes counter, then branches to vector
// - Pin falling edge sets pin pending bit 4
// - Pin service calls 04h, clears pending and global
// - Timer overflow sets timer pending bit 5
// - Timer service calls 08h, clears pending and global
// - Return-reenable sets global enable; plain return not
// - Requests evaluated at next phase-two rising edge
// - Pin request outranks timer request
// - Control bits: global, pin, timer enables; bit3 zero
// - Pending flags stay until serviced or cleared
`timescale 1ns/100ps
`default_nettype none
`include "sfirq_defines.svh"

module sfirq_core (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   input wire logic [`SFIRQ_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire sfirq_pkg::sfirq_alu_s alu_in,
   input wire logic sleep_instr_in,
   input wire logic watchdog_kick_instr_in,
   input wire logic watchdog_timeout_in,
   input wire logic return_reenable_instr_in,
   input wire logic subroutine_exit_instr_in,
   input wire logic stack_full_in,
   input wire logic pin_irq_n_in,
   input wire logic timer_overflow_in,
   input wire logic phase_two_pulse_in,
   output logic vector_call_out,
   output logic [`SFIRQ_PC_W-1:0] vector_addr_out,
   output logic [7:0] alu_result_out,
   output logic [7:0] flag_status_out,
   output logic [7:0] irq_control_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   sfirq_pkg::sfirq_state_s s_q;
   sfirq_pkg::sfirq_state_s s_d;
   logic wr_status;
   logic wr_ictrl;
   logic pin_fall;
   logic t2_rise;
   logic pin_ok;
   logic tmr_ok;
   logic fire;
   logic exp_c;
   logic exp_ov;
   logic [7:0] addend;
   logic [4:0] sum_lo;
   logic [7:0] sum_lo7;
   logic [8:0] sum_all;

   // Register decode, shared by read and write paths
   function automatic logic [1:0] reg_hit(input logic [`SFIRQ_ADDR_W-1:0] addr);
      logic [1:0] hit;
      hit = 2'b00;
      if (addr == `SFIRQ_ADDR_W'(`SFIRQ_ADDR_STATUS)) begin
         hit = 2'b01;
      end else if (addr == `SFIRQ_ADDR_W'(`SFIRQ_ADDR_ICTRL)) begin
         hit = 2'b10;
      end else begin
         hit = 2'b00;
      end
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register images, unused bits forced to zero

   function automatic logic [7:0] status_image(input sfirq_pkg::sfirq_state_s s);
      logic [7:0] v;
      v = `SFIRQ_ZERO_BYTE; // Bits 6 and 7 stay zero
      v[`SFIRQ_ST_C] = s.c;
      v[`SFIRQ_ST_AC] = s.ac;
      v[`SFIRQ_ST_Z] = s.z;
      v[`SFIRQ_ST_OV] = s.ov;
      v[`SFIRQ_ST_SLEEP] = s.sleep;
      v[`SFIRQ_ST_WDOG] = s.wdog;
      return v;
   endfunction

   function automatic logic [7:0] ictrl_image(input sfirq_pkg::sfirq_state_s s);
      logic [7:0] v;
      v = `SFIRQ_ZERO_BYTE; // Bit 3 and top bits read zero
      v[`SFIRQ_IC_GLOBAL] = s.gie;
      v[`SFIRQ_IC_PIN_EN] = s.pin_en;
      v[`SFIRQ_IC_TMR_EN] = s.tmr_en;
      v[`SFIRQ_IC_PIN_PEND] = s.pin_pend;
      v[`SFIRQ_IC_TMR_PEND] = s.tmr_pend;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      s_d = s_q;
      s_d.call = 1'b0;

      // Write commits at the edge where waitrequest is seen low
      wr_status = avs_write_in && avs_byteenable_in[0] &&
                  (s_q.bus == sfirq_pkg::SFIRQ_BUS_ACK) &&
                  (reg_hit(avs_address_in) == 2'b01);
      wr_ictrl = avs_write_in && avs_byteenable_in[0] &&
                 (s_q.bus == sfirq_pkg::SFIRQ_BUS_ACK) &&
                 (reg_hit(avs_address_in) == 2'b10);

      // Bus answer: one wait cycle, then one acknowledge cycle
      if (s_q.bus == sfirq_pkg::SFIRQ_BUS_WAIT) begin
         if (avs_read_in || avs_write_in) begin
            s_d.bus = sfirq_pkg::SFIRQ_BUS_ACK;
            if (reg_hit(avs_address_in) == 2'b01) begin
               s_d.rdata = status_image(s_q);
            end else if (reg_hit(avs_address_in) == 2'b10) begin
               s_d.rdata = ictrl_image(s_q);
            end else begin
               s_d.rdata = `SFIRQ_ZERO_BYTE; // Unmapped reads return zero
            end
         end
      end else begin
         s_d.bus = sfirq_pkg::SFIRQ_BUS_WAIT;
      end

      // Arithmetic: subtraction adds the inverted operand, carry means no borrow
      addend = (alu_in.op == sfirq_pkg::SFIRQ_OP_SUB) ? ~alu_in.b : alu_in.b;
      sum_lo = {1'b0, alu_in.a[3:0]} + {1'b0, addend[3:0]} + {4'h0, alu_in.cin};
      sum_lo7 = {1'b0, alu_in.a[6:0]} + {1'b0, addend[6:0]} + {7'h00, alu_in.cin};
      sum_all = {1'b0, alu_in.a} + {1'b0, addend} + {8'h00, alu_in.cin};
      exp_c = sum_all[8];
      exp_ov = sum_lo7[7] ^ sum_all[8];

      // Flag update from the reported data operation
      if (alu_in.valid) begin
         case (alu_in.op)
            sfirq_pkg::SFIRQ_OP_ADD, sfirq_pkg::SFIRQ_OP_SUB: begin
               s_d.result = sum_all[7:0];
               s_d.c = exp_c;
               s_d.ac = sum_lo[4];
               s_d.ov = exp_ov;
               s_d.z = (sum_all[7:0] == `SFIRQ_ZERO_BYTE);
            end
            sfirq_pkg::SFIRQ_OP_RLC: begin
               s_d.result = {alu_in.a[6:0], s_q.c};
               s_d.c = alu_in.a[7];
            end
            sfirq_pkg::SFIRQ_OP_RRC: begin
               s_d.result = {s_q.c, alu_in.a[7:1]};
               s_d.c = alu_in.a[0];
            end
            default: begin
               s_d.result = alu_in.result;
               s_d.z = (alu_in.result == `SFIRQ_ZERO_BYTE);
            end
         endcase
      end

      // Software write to status: only arithmetic flags are taken
      if (wr_status) begin
         s_d.c = avs_writedata_in[`SFIRQ_ST_C];
         s_d.ac = avs_writedata_in[`SFIRQ_ST_AC];
         s_d.z = avs_writedata_in[`SFIRQ_ST_Z];
         s_d.ov = avs_writedata_in[`SFIRQ_ST_OV]; // Sleep and watchdog kept
      end

      // Sleep and watchdog flags; a time-out wins over a clear
      if (sleep_instr_in) begin
         s_d.sleep = 1'b1;
         s_d.wdog = 1'b0;
      end
      if (watchdog_kick_instr_in) begin
         s_d.sleep = 1'b0;
         s_d.wdog = 1'b0;
      end
      if (watchdog_timeout_in) begin
         s_d.wdog = 1'b1;
      end

      // Request edges and the phase-two sampling point
      pin_fall = s_q.pin_prev && !pin_irq_n_in;
      t2_rise = phase_two_pulse_in && !s_q.t2_prev;
      s_d.pin_prev = pin_irq_n_in;
      s_d.t2_prev = phase_two_pulse_in;

      // Eligibility at the sampling point, pin first
      // A request landing on the sampling edge itself waits for the next pulse
      pin_ok = s_q.pin_pend && s_q.pin_en;
      tmr_ok = s_q.tmr_pend && s_q.tmr_en;
      fire = t2_rise && s_q.gie && !stack_full_in && (pin_ok || tmr_ok);

      // Control register write
      if (wr_ictrl) begin
         s_d.gie = avs_writedata_in[`SFIRQ_IC_GLOBAL];
         s_d.pin_en = avs_writedata_in[`SFIRQ_IC_PIN_EN];
         s_d.tmr_en = avs_writedata_in[`SFIRQ_IC_TMR_EN];
         s_d.pin_pend = avs_writedata_in[`SFIRQ_IC_PIN_PEND];
         s_d.tmr_pend = avs_writedata_in[`SFIRQ_IC_TMR_PEND];
      end
      if (return_reenable_instr_in) begin
         s_d.gie = 1'b1; // Plain return has no effect here
      end

      // Vectored entry: counter push pulse and vector, no status save
      if (fire) begin
         s_d.call = 1'b1;
         s_d.gie = 1'b0;
         if (pin_ok) begin
            s_d.vec = `SFIRQ_VEC_PIN;
            s_d.pin_pend = 1'b0;
         end else begin
            s_d.vec = `SFIRQ_VEC_TIMER;
            s_d.tmr_pend = 1'b0;
         end
      end

      // New requests set pending last, so they win over any clear
      if (pin_fall) begin
         s_d.pin_pend = 1'b1;
      end
      if (timer_overflow_in) begin
         s_d.tmr_pend = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register, frozen while the clock enable is low

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_q <= sfirq_pkg::SFIRQ_STATE_RST;
      end else if (clk_en_in) begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign avs_waitrequest_out = s_q.bus;
   assign avs_readdata_out = {`SFIRQ_RDATA_PAD, s_q.rdata};
   assign vector_call_out = s_q.call;
   assign vector_addr_out = s_q.vec;
   assign alu_result_out = s_q.result;
   assign flag_status_out = status_image(s_q);
   assign irq_control_out = ictrl_image(s_q);

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   // Sampling point taken, and the entry it produces one cycle later
   sequence seq_fire;
      clk_en_in && fire;
   endsequence

   sequence seq_entry(logic [`SFIRQ_PC_W-1:0] v);
      vector_call_out && !irq_control_out[`SFIRQ_IC_GLOBAL] && vector_addr_out == v;
   endsequence

   // Status register checks
   a_unused_bits_zero: assert property (flag_status_out[7:6] == 2'b00)
      else $error("status unused bits not zero");

   a_status_write_guard: assert property (clk_en_in && wr_status && !sleep_instr_in &&
         !watchdog_kick_instr_in && !watchdog_timeout_in
         |=> $stable(flag_status_out[`SFIRQ_ST_WDOG]) && $stable(flag_status_out[`SFIRQ_ST_SLEEP]))
      else $error("status write changed sleep or watchdog flag");

   a_timeout_sets_flag: assert property (clk_en_in && watchdog_timeout_in
         |=> flag_status_out[`SFIRQ_ST_WDOG])
      else $error("watchdog flag not set on time-out");

   a_sleep_sets_flag: assert property (clk_en_in && sleep_instr_in &&
         !watchdog_kick_instr_in && !watchdog_timeout_in
         |=> flag_status_out[`SFIRQ_ST_SLEEP] && !flag_status_out[`SFIRQ_ST_WDOG])
      else $error("sleep did not set sleep flag and clear watchdog flag");

   a_carry_from_add: assert property (clk_en_in && alu_in.valid && !wr_status &&
         alu_in.op == sfirq_pkg::SFIRQ_OP_ADD |=> flag_status_out[`SFIRQ_ST_C] == $past(exp_c))
      else $error("carry flag wrong after addition");

   a_overflow_flag: assert property (clk_en_in && alu_in.valid && !wr_status &&
         alu_in.op == sfirq_pkg::SFIRQ_OP_SUB |=> flag_status_out[`SFIRQ_ST_OV] == $past(exp_ov))
      else $error("overflow flag wrong after subtraction");

   // Interrupt entry checks
   a_full_stack_block: assert property (clk_en_in && stack_full_in |=> !vector_call_out)
      else $error("interrupt taken with stack full");

   a_pin_entry_seq: assert property (seq_fire ##0 pin_ok |=> seq_entry(`SFIRQ_VEC_PIN))
      else $error("pin interrupt entry wrong");

   a_timer_entry_seq: assert property (seq_fire ##0 !pin_ok
         |=> seq_entry(`SFIRQ_VEC_TIMER))
      else $error("timer interrupt entry wrong");

   a_pin_edge_pending: assert property (clk_en_in && pin_fall
         |=> irq_control_out[`SFIRQ_IC_PIN_PEND])
      else $error("pin falling edge lost");

   a_reenable_global: assert property (clk_en_in && return_reenable_instr_in && !fire
         |=> irq_control_out[`SFIRQ_IC_GLOBAL])
      else $error("return with reenable left global enable clear");

   // Further flag checks
   a_kick_clears_flags: assert property (clk_en_in && watchdog_kick_instr_in &&
         !watchdog_timeout_in |=> !flag_status_out[`SFIRQ_ST_SLEEP] &&
         !flag_status_out[`SFIRQ_ST_WDOG])
      else $error("watchdog kick left sleep or watchdog flag set");

   a_zero_from_logic: assert property (clk_en_in && alu_in.valid && !wr_status &&
         alu_in.op == sfirq_pkg::SFIRQ_OP_LOGIC
         |=> flag_status_out[`SFIRQ_ST_Z] == (alu_result_out == `SFIRQ_ZERO_BYTE))
      else $error("zero flag does not follow logic result");

   a_rotate_carry: assert property (clk_en_in && alu_in.valid && !wr_status &&
         alu_in.op == sfirq_pkg::SFIRQ_OP_RLC
         |=> flag_status_out[`SFIRQ_ST_C] == $past(alu_in.a[7]))
      else $error("carry flag wrong after rotate left");

   // Pending flags leave only by service or software
   a_timer_sets_pend: assert property (clk_en_in && timer_overflow_in
         |=> irq_control_out[`SFIRQ_IC_TMR_PEND])
      else $error("timer overflow lost");

   a_pin_pend_held: assert property (clk_en_in && !wr_ictrl && !(fire && pin_ok) &&
         irq_control_out[`SFIRQ_IC_PIN_PEND] |=> irq_control_out[`SFIRQ_IC_PIN_PEND])
      else $error("pin pending flag dropped without service");

   a_tmr_pend_held: assert property (clk_en_in && !wr_ictrl && !(fire && !pin_ok) &&
         irq_control_out[`SFIRQ_IC_TMR_PEND] |=> irq_control_out[`SFIRQ_IC_TMR_PEND])
      else $error("timer pending flag dropped without service");

   // Entry gating and return checks
   a_blocked_no_call: assert property (clk_en_in && !irq_control_out[`SFIRQ_IC_GLOBAL]
         |=> !vector_call_out)
      else $error("interrupt taken with global enable clear");

   a_call_one_cycle: assert property (clk_en_in && vector_call_out |=> !vector_call_out)
      else $error("vector call longer than one cycle");

   a_plain_return_keep: assert property (clk_en_in && subroutine_exit_instr_in &&
         !return_reenable_instr_in && !wr_ictrl && !fire
         |=> $stable(irq_control_out[`SFIRQ_IC_GLOBAL]))
      else $error("plain return changed global enable");

   a_ctrl_write_takes: assert property (clk_en_in && wr_ictrl && !fire &&
         !return_reenable_instr_in
         |=> irq_control_out[`SFIRQ_IC_TMR_EN:`SFIRQ_IC_GLOBAL] ==
         $past(avs_writedata_in[`SFIRQ_IC_TMR_EN:`SFIRQ_IC_GLOBAL]))
      else $error("control enables not taken from write");

endmodule // sfirq_core

`default_nettype wire

/* design/sfirq_defines.svh */
// Constants for the status flag and interrupt control block
`ifndef SFIRQ_DEFINES_SVH
`define SFIRQ_DEFINES_SVH

// Register indices and Avalon byte addresses (index times four)
`define SFIRQ_ADDR_W 8
`define SFIRQ_IDX_STATUS 8'h0a
`define SFIRQ_IDX_ICTRL 8'h0b
`define SFIRQ_ADDR_STATUS (`SFIRQ_IDX_STATUS << 2)
`define SFIRQ_ADDR_ICTRL (`SFIRQ_IDX_ICTRL << 2)

// Status register bit positions
`define SFIRQ_ST_C 0
`define SFIRQ_ST_AC 1
`define SFIRQ_ST_Z 2
`define SFIRQ_ST_OV 3
`define SFIRQ_ST_SLEEP 4
`define SFIRQ_ST_WDOG 5

// Interrupt control bit positions
`define SFIRQ_IC_GLOBAL 0
`define SFIRQ_IC_PIN_EN 1
`define SFIRQ_IC_TMR_EN 2
`define SFIRQ_IC_PIN_PEND 4
`define SFIRQ_IC_TMR_PEND 5

// Vector addresses and widths
`define SFIRQ_PC_W 10
`define SFIRQ_VEC_PIN 10'h004
`define SFIRQ_VEC_TIMER 10'h008
`define SFIRQ_VEC_NONE 10'h000

// Reset values
`define SFIRQ_RST_BIT 1'b0
`define SFIRQ_RST_PIN 1'b1
`define SFIRQ_RST_BYTE 8'h00
`define SFIRQ_ZERO_BYTE 8'h00
`define SFIRQ_RDATA_PAD 24'h000000

`endif

/* design/sfirq_pkg.sv */
// Types for the status flag and interrupt control block
`include "sfirq_defines.svh"
package sfirq_pkg;

   // Kind of data operation the sequencer reports
   typedef enum logic [2:0] {
      SFIRQ_OP_ADD = 3'b000,
      SFIRQ_OP_SUB = 3'b001,
      SFIRQ_OP_LOGIC = 3'b010,
      SFIRQ_OP_RLC = 3'b011,
      SFIRQ_OP_RRC = 3'b100
   } sfirq_op_e;

   // Bus answer phase; the code is the waitrequest level itself
   typedef enum logic {
      SFIRQ_BUS_ACK = 1'b0,
      SFIRQ_BUS_WAIT = 1'b1
   } sfirq_bus_e;

   // One data operation from the sequencer
   typedef struct packed {
      logic valid;
      sfirq_op_e op;
      logic [7:0] a;
      logic [7:0] b;
      logic cin;
      logic [7:0] result;
   } sfirq_alu_s;

   // Whole state of the block
   typedef struct packed {
      sfirq_bus_e bus;
      logic [7:0] rdata;
      logic c;
      logic ac;
      logic z;
      logic ov;
      logic sleep;
      logic wdog;
      logic gie;
      logic pin_en;
      logic tmr_en;
      logic pin_pend;
      logic tmr_pend;
      logic pin_prev;
      logic t2_prev;
      logic call;
      logic [`SFIRQ_PC_W-1:0] vec;
      logic [7:0] result;
   } sfirq_state_s;

   localparam sfirq_state_s SFIRQ_STATE_RST = '{
      bus: SFIRQ_BUS_WAIT, rdata: `SFIRQ_RST_BYTE,
      c: `SFIRQ_RST_BIT, ac: `SFIRQ_RST_BIT, z: `SFIRQ_RST_BIT, ov: `SFIRQ_RST_BIT,
      sleep: `SFIRQ_RST_BIT, wdog: `SFIRQ_RST_BIT,
      gie: `SFIRQ_RST_BIT, pin_en: `SFIRQ_RST_BIT, tmr_en: `SFIRQ_RST_BIT,
      pin_pend: `SFIRQ_RST_BIT, tmr_pend: `SFIRQ_RST_BIT,
      pin_prev: `SFIRQ_RST_PIN, t2_prev: `SFIRQ_RST_BIT, call: `SFIRQ_RST_BIT,
      vec: `SFIRQ_VEC_NONE, result: `SFIRQ_RST_BYTE};

endpackage

/* testbench/sfirq_seq_model.sv */
// Sequencer, stack depth and phase pulse model facing the status and irq block
`timescale 1ns/100ps
`default_nettype none
module sfirq_seq_model (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic vector_call_in,
   input wire logic push_req_in,
   input wire logic ret_req_in,
   input wire logic return_reenable_instr_req_in,
   output logic stack_full_out,
   output logic phase_two_out,
   output logic subroutine_exit_out,
   output logic return_reenable_out
);
   localparam int LEVELS = 4;
   logic [2:0] depth_q;
   logic [1:0] phase_q;
   // Stack depth; an entry pushes only the program counter
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         depth_q <= 3'h0;
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
         if ((vector_call_in || push_req_in) && depth_q < 3'(LEVELS)) begin
            depth_q <= depth_q + 3'h1;
         end else if ((ret_req_in || return_reenable_instr_req_in) && depth_q != 3'h0) begin
            depth_q <= depth_q - 3'h1;
         end
      end
   end
   // Full flag, phase pulse every fourth cycle, return strobes
   assign stack_full_out = (depth_q == 3'(LEVELS));
   assign phase_two_out = (phase_q == 2'h3);
   assign subroutine_exit_out = ret_req_in;
   assign return_reenable_out = return_reenable_instr_req_in;
endmodule // sfirq_seq_model
`default_nettype wire

/* testbench/test_sfirq_core.sv */
// Self-checking bench for the status flag and interrupt control block
`timescale 1ns/100ps
`default_nettype none
`include "sfirq_defines.svh"
module test_sfirq_core;
   localparam logic [7:0] A_ST = `SFIRQ_ADDR_STATUS;
   localparam logic [7:0] A_IC = `SFIRQ_ADDR_ICTRL;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
   logic [3:0] avs_byteenable = 4'h1;
   logic clk_en = 1'b1;
   logic [9:0] call_vec = 10'h000;
   logic avs_waitrequest, stack_full, phase_two, sub_exit, return_reenable_instr_p, call, pin_n = 1'b1;
   sfirq_pkg::sfirq_alu_s alu = '0;
   logic [6:0] strb = 7'h00; // sleep kick tmo tovf push ret return_reenable_instr
   logic [9:0] vec;
   logic [7:0] result, flags, ictrl;
   int error_cnt = 0, n_checks = 0, calls = 0, c0;

   sfirq_core DUT (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en),
      .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
      .avs_writedata_in(avs_writedata), .avs_byteenable_in(avs_byteenable),
      .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
      .alu_in(alu), .sleep_instr_in(strb[0]), .watchdog_kick_instr_in(strb[1]),
      .watchdog_timeout_in(strb[2]), .return_reenable_instr_in(return_reenable_instr_p),
      .subroutine_exit_instr_in(sub_exit), .stack_full_in(stack_full),
      .pin_irq_n_in(pin_n), .timer_overflow_in(strb[3]), .phase_two_pulse_in(phase_two),
      .vector_call_out(call), .vector_addr_out(vec), .alu_result_out(result),
      .flag_status_out(flags), .irq_control_out(ictrl));
   sfirq_seq_model seq (.clk_in(clk_in), .reset_in(reset_in), .vector_call_in(call),
      .push_req_in(strb[4]), .ret_req_in(strb[5]), .return_reenable_instr_req_in(strb[6]),
      .stack_full_out(stack_full), .phase_two_out(phase_two),
      .subroutine_exit_out(sub_exit), .return_reenable_out(return_reenable_instr_p));
   ////////////////////////////////////////////////////////////////////////////
   // Clock and call counter
   initial begin
      forever #2 clk_in = ~clk_in;
   end
   // Call cycles counted mid-cycle, where the design output has settled
   always @(negedge clk_in) begin
      if (call === 1'b1) begin
         calls++;
         call_vec = vec;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                      output logic [7:0] rd);
      int n;
      n = 0;
      avs_address <= addr;
      avs_writedata <= {24'h000000, wd};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_in);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk_in);
         n++;
      end
      chk(10'(n), 10'h001);
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic wr_reg(input logic [7:0] addr, input logic [7:0] wd);
      logic [7:0] rd;
      bus(1'b1, addr, wd, rd);
   endtask
   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] rd;
      bus(1'b0, addr, 8'h00, rd);
      chk({2'b00, rd}, {2'b00, exp});
   endtask
   task automatic strobe(input int b);
      strb[b] <= 1'b1;
      @(posedge clk_in);
      strb <= 7'h00;
      @(posedge clk_in);
   endtask
   task automatic pin_fall();
      pin_n <= 1'b0;
      repeat (2) @(posedge clk_in);
      pin_n <= 1'b1;
      @(posedge clk_in);
   endtask
   task automatic alu_op(input sfirq_pkg::sfirq_op_e op, input logic [7:0] a, b,
                         input logic cin, input logic [7:0] res, exp_r, exp_f);
      alu <= '{1'b1, op, a, b, cin, res};
      @(posedge clk_in);
      alu.valid <= 1'b0;
      @(negedge clk_in);
      chk({2'b00, result}, {2'b00, exp_r});
      chk({2'b00, flags}, {2'b00, exp_f});
      @(posedge clk_in);
   endtask
   // Waits for a vectored call after c_start, then checks it lasted one cycle
   task automatic wait_call(input int c_start, input logic [9:0] exp_v);
      int n;
      n = 0;
      while (calls == c_start && n < 12) begin
         @(posedge clk_in);
         n++;
      end
      @(posedge clk_in);
      chk(10'(calls - c_start), 10'h001);
      chk(call_vec, exp_v);
      chk(vec, exp_v);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Watchdog on the whole run
   initial begin
      #40000;
      error_cnt++;
      $display("ERROR %0t: run timed out", $time);
      give_verdict();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      rd_chk(A_ST, 8'h00);
      wr_reg(8'h00, 8'hff);
      rd_chk(8'h00, 8'h00);
      wr_reg(A_IC, 8'h0f);
      rd_chk(A_IC, 8'h07);
      wr_reg(A_ST, 8'hff);
      rd_chk(A_ST, 8'h0f);
      avs_byteenable <= 4'h0;
      wr_reg(A_ST, 8'h00);
      avs_byteenable <= 4'h1;
      rd_chk(A_ST, 8'h0f);
      strobe(2);
      rd_chk(A_ST, 8'h2f);
      wr_reg(A_ST, 8'h00);
      rd_chk(A_ST, 8'h20);
      strobe(0);
      rd_chk(A_ST, 8'h10);
      strobe(1);
      rd_chk(A_ST, 8'h00);
      clk_en <= 1'b0;
      strobe(2);
      clk_en <= 1'b1;
      rd_chk(A_ST, 8'h00);
      // Arithmetic, logic and rotate flag table
      alu_op(sfirq_pkg::SFIRQ_OP_ADD, 8'h7f, 8'h01, 1'b0, 8'h00, 8'h80, 8'h0a);
      alu_op(sfirq_pkg::SFIRQ_OP_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 8'h00, 8'h07);
      alu_op(sfirq_pkg::SFIRQ_OP_SUB, 8'h10, 8'h01, 1'b1, 8'h00, 8'h0f, 8'h01);
      alu_op(sfirq_pkg::SFIRQ_OP_LOGIC, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 8'h05);
      alu_op(sfirq_pkg::SFIRQ_OP_RLC, 8'h80, 8'h00, 1'b0, 8'h00, 8'h01, 8'h05);
      alu_op(sfirq_pkg::SFIRQ_OP_RRC, 8'h02, 8'h00, 1'b0, 8'h00, 8'h81, 8'h04);
      // Pin request served at the next phase pulse
      c0 = calls;
      wr_reg(A_IC, 8'h03);
      pin_fall();
      wait_call(c0, `SFIRQ_VEC_PIN);
      rd_chk(A_IC, 8'h02);
      rd_chk(A_ST, 8'h04);
      strobe(6);
      rd_chk(A_IC, 8'h03);
      wr_reg(A_IC, 8'h06);
      strobe(5);
      rd_chk(A_IC, 8'h06);
      // Blocked requests stay pending, then served by priority
      c0 = calls;
      pin_fall();
      strobe(3);
      repeat (12) @(posedge clk_in);
      chk(10'(calls - c0), 10'h000);
      rd_chk(A_IC, 8'h36);
      chk({2'b00, ictrl}, 10'h036);
      wr_reg(A_IC, 8'h37);
      wait_call(c0, `SFIRQ_VEC_PIN);
      rd_chk(A_IC, 8'h26);
      c0 = calls;
      strobe(6);
      wait_call(c0, `SFIRQ_VEC_TIMER);
      rd_chk(A_IC, 8'h06);
      // Full stack holds the acknowledgement back
      repeat (3) strobe(4);
      wr_reg(A_IC, 8'h03);
      c0 = calls;
      pin_fall();
      repeat (12) @(posedge clk_in);
      chk(10'(calls - c0), 10'h000);
      rd_chk(A_IC, 8'h13);
      c0 = calls;
      strobe(5);
      wait_call(c0, `SFIRQ_VEC_PIN);
      give_verdict();
   end
endmodule // test_sfirq_core
`default_nettype wire
